// [hw/pacl_top.sv]
// rule table indirect access: wishbone registers, transfer control, table
//
// Summary of operation
// - each port has its own table, reached only through staging and control registers.
// - mode field 00 none, 01 layer-2, 10 layer-3, 11 layer-4 filtering.
// - a 16-bit mask picks which staged bytes move to or from the entry.
// - writing the low mask byte launches; direction bit and 4-bit index steer it.
// - upper mask bit 0 selects staging byte 7, bit 7 selects byte 0.
// - lower mask bit 0 selects staging byte 15, bit 7 selects byte 8.
// - mask 1 includes a byte; 0 leaves staging and table byte untouched.
// - control bit 6 reads 1 when no write pending, 0 while writing.
// - control bit 5 reads 1 when read done; software polls before using results.
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pacl_top
    import pacl_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [pacl_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    input  wire logic                   wb_we_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    output logic                        wb_ack_o,
    input  wire logic [3:0]             match_index_i,
    output logic [pacl_pkg::RULE_W-1:0] match_rule_o,
    output pacl_pkg::pacl_mode_t        match_mode_o
);
    import pacl_pkg::*;

    typedef enum logic {
        ST_IDLE,
        ST_ACCESS
    } pacl_state_t;

    pacl_state_t       state;
    pacl_state_t       next_state;
    logic [7:0]        stage [N_BYTES];
    logic [7:0]        mask_hi;
    logic [7:0]        mask_lo;
    logic              ctrl_dir;
    logic [3:0]        ctrl_index;
    logic              wr_done;
    logic              rd_done;
    logic              xfer_dir;
    logic [3:0]        xfer_index;
    logic [N_BYTES-1:0] xfer_en;

    pacl_tbl_if tbl ();

    // byte b of a flat rule word
    function automatic logic [7:0] rule_byte(input logic [RULE_W-1:0] w, input int b);
        return w[8*b +: 8];
    endfunction

    // register index compare, shared by the mask and control decodes
    function automatic logic idx_hit(input logic [5:0] idx, input logic [5:0] target);
        return idx == target;
    endfunction

    // bus decode
    wire [5:0]  reg_idx   = wb_adr_i[ADR_W-1:ADR_LSB];
    wire        req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr_lane0  = req & wb_we_i & wb_sel_i[0];
    wire        hit_stage = (reg_idx <= IDX_STAGE_LAST);
    wire        hit_mhi   = idx_hit(reg_idx, IDX_MASK_HI);
    wire        hit_mlo   = idx_hit(reg_idx, IDX_MASK_LO);
    wire        hit_ctrl  = idx_hit(reg_idx, IDX_CTRL);
    wire [7:0]  wbyte     = wb_dat_i[7:0];
    wire        launch    = wr_lane0 & hit_mlo & (state == ST_IDLE);
    wire        in_access = (state == ST_ACCESS);
    wire        do_write  = in_access & (xfer_dir == DIR_WRITE);
    wire        do_read   = in_access & (xfer_dir == DIR_READ);
    wire [7:0]  ctrl_word = {1'b0, wr_done, rd_done, ctrl_dir, ctrl_index};

    // enables from the mask as it stands once this write lands
    logic [N_BYTES-1:0] launch_en;
    pacl_sel_map u_sel_map (
        .mask_hi_i (mask_hi),
        .mask_lo_i (wbyte),
        .byte_en_o (launch_en)
    );

    wire [7:0] rd_byte = hit_stage ? stage[reg_idx[3:0]] :
                         hit_mhi   ? mask_hi :
                         hit_mlo   ? mask_lo :
                         hit_ctrl  ? ctrl_word : 8'h00;

    // table side; only this engine touches the entries
    logic [RULE_W-1:0] stage_flat;
    always_comb begin
        stage_flat = '0;
        for (int b = 0; b < N_BYTES; b++) begin
            stage_flat[8*b +: 8] = stage[b];
        end
    end
    assign tbl.index    = xfer_index;
    assign tbl.wr_en    = do_write;
    assign tbl.byte_en  = xfer_en;
    assign tbl.wr_data  = stage_flat;
    assign tbl.lk_index = match_index_i;

    pacl_table u_table (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tbl   (tbl)
    );

    // one-cycle transfer; a second launch while busy is not taken
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (launch) begin
                    next_state = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // bus answer: one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // read data zero-extended; upper lanes never carry anything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // transfer parameters latched at launch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xfer_dir   <= DIR_READ;
            xfer_index <= INDEX_RST;
        end else if (launch) begin
            xfer_dir   <= ctrl_dir;
            xfer_index <= ctrl_index;
        end
    end

    // enables frozen at launch so a later mask write cannot disturb it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xfer_en <= '0;
        end else if (launch) begin
            xfer_en <= launch_en;
        end
    end

    // register write strobes, low lane only
    wire wr_mhi  = wr_lane0 & hit_mhi;
    wire wr_mlo  = wr_lane0 & hit_mlo;
    wire wr_ctrl = wr_lane0 & hit_ctrl;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_hi <= MASK_RST;
        end else if (wr_mhi) begin
            mask_hi <= wbyte;
        end
    end

    // stored even when the launch itself is refused
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_lo <= MASK_RST;
        end else if (wr_mlo) begin
            mask_lo <= wbyte;
        end
    end

    // flag bits of the written byte are read-only and dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_dir   <= DIR_READ;
            ctrl_index <= INDEX_RST;
        end else if (wr_ctrl) begin
            ctrl_dir   <= wbyte[CTRL_DIR];
            ctrl_index <= wbyte[CTRL_IDX_HI:0];
        end
    end

    // completion flags: launch clears, finished access sets; set wins
    wire wr_done_set = do_write;
    wire wr_done_clr = launch & (ctrl_dir == DIR_WRITE);
    wire rd_done_set = do_read;
    wire rd_done_clr = launch & (ctrl_dir == DIR_READ);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_done <= DONE_RST;
        end else if (wr_done_set) begin
            wr_done <= 1'b1;
        end else if (wr_done_clr) begin
            wr_done <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_done <= DONE_RST;
        end else if (rd_done_set) begin
            rd_done <= 1'b1;
        end else if (rd_done_clr) begin
            rd_done <= 1'b0;
        end
    end

    // per-byte staging strobes; table read-back wins over a software write
    logic [N_BYTES-1:0] stage_ld;
    logic [N_BYTES-1:0] stage_sw;
    always_comb begin
        stage_ld = '0;
        stage_sw = '0;
        for (int b = 0; b < N_BYTES; b++) begin
            stage_ld[b] = do_read & xfer_en[b];
            stage_sw[b] = wr_lane0 & hit_stage & (reg_idx[3:0] == 4'(b));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int b = 0; b < N_BYTES; b++) begin
                stage[b] <= STAGE_RST;
            end
        end else begin
            for (int b = 0; b < N_BYTES; b++) begin
                if (stage_ld[b]) begin
                    stage[b] <= rule_byte(tbl.rd_data, b);
                end else if (stage_sw[b]) begin
                    stage[b] <= wbyte;
                end
            end
        end
    end

    // registered lookup for the matching logic outside
    wire [7:0] mode_byte = rule_byte(tbl.lk_data, MODE_BYTE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_rule_o <= '0;
        end else begin
            match_rule_o <= tbl.lk_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_mode_o <= PACL_MODE_NONE;
        end else begin
            match_mode_o <= pacl_mode_t'(mode_byte[MODE_LSB +: 2]);
        end
    end
endmodule
`default_nettype wire

// [hw/pacl_pkg.sv]
// constants and types shared by the rule table access block
package pacl_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_STAGE_FIRST = 6'h00;
    localparam logic [5:0] IDX_STAGE_LAST  = 6'h0f;
    localparam logic [5:0] IDX_MASK_HI     = 6'h10;
    localparam logic [5:0] IDX_MASK_LO     = 6'h11;
    localparam logic [5:0] IDX_CTRL        = 6'h12;
    localparam int         ADR_W           = 8;
    localparam int         ADR_LSB         = 2;
    // table geometry
    localparam int         N_BYTES         = 16;
    localparam int         N_ENTRIES       = 16;
    localparam int         RULE_W          = 8 * N_BYTES;
    // control register fields
    localparam int         CTRL_WR_DONE    = 6;
    localparam int         CTRL_RD_DONE    = 5;
    localparam int         CTRL_DIR        = 4;
    localparam int         CTRL_IDX_HI     = 3;
    localparam logic       DIR_WRITE       = 1'b1;
    localparam logic       DIR_READ        = 1'b0;
    // reset values
    localparam logic [7:0] STAGE_RST       = 8'h00;
    localparam logic [7:0] MASK_RST        = 8'h00;
    localparam logic [3:0] INDEX_RST       = 4'h0;
    localparam logic       DONE_RST        = 1'b1;
    // filtering mode field sits in staging byte 1, bits 5:4
    localparam int         MODE_BYTE       = 1;
    localparam int         MODE_LSB        = 4;

    typedef enum logic [1:0] {
        PACL_MODE_NONE = 2'b00,
        PACL_MODE_L2   = 2'b01,
        PACL_MODE_L3   = 2'b10,
        PACL_MODE_L4   = 2'b11
    } pacl_mode_t;

    // reverses a mask byte so bit 0 lands on the highest staging byte of its half
    function automatic logic [7:0] pacl_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[7 - i] = v[i];
        end
        return r;
    endfunction
endpackage

// [hw/pacl_tbl_if.sv]
// link between the transfer logic and the per-port rule table
`timescale 1ns/1ps
`default_nettype none
interface pacl_tbl_if;
    import pacl_pkg::*;
    logic [3:0]        index;
    logic              wr_en;
    logic [N_BYTES-1:0] byte_en;
    logic [RULE_W-1:0] wr_data;
    logic [RULE_W-1:0] rd_data;
    logic [3:0]        lk_index;
    logic [RULE_W-1:0] lk_data;

    modport engine (output index, wr_en, byte_en, wr_data, lk_index, input rd_data, lk_data);
    modport store  (input index, wr_en, byte_en, wr_data, lk_index, output rd_data, lk_data);
endinterface
`default_nettype wire

// [hw/pacl_sel_map.sv]
// maps the 16-bit byte-select mask onto staging byte enables
`timescale 1ns/1ps
`default_nettype none
module pacl_sel_map
    import pacl_pkg::*;
(
    input  wire logic [7:0]         mask_hi_i,
    input  wire logic [7:0]         mask_lo_i,
    output logic [pacl_pkg::N_BYTES-1:0] byte_en_o
);
    // high byte bit i -> stage 7-i, low byte bit i -> stage 15-i
    assign byte_en_o = {pacl_rev8(mask_lo_i), pacl_rev8(mask_hi_i)};
endmodule
`default_nettype wire

// [hw/pacl_table.sv]
// per-port rule table storage, flip-flops indexed by entry
`timescale 1ns/1ps
`default_nettype none
module pacl_table
    import pacl_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    pacl_tbl_if.store  tbl
);
    logic [RULE_W-1:0] mem [N_ENTRIES];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int e = 0; e < N_ENTRIES; e++) begin
                mem[e] <= '0;
            end
        end else if (tbl.wr_en) begin
            for (int b = 0; b < N_BYTES; b++) begin
                if (tbl.byte_en[b]) begin
                    mem[tbl.index][8*b +: 8] <= tbl.wr_data[8*b +: 8];
                end
            end
        end
    end

    assign tbl.rd_data = mem[tbl.index];
    assign tbl.lk_data = mem[tbl.lk_index];
endmodule
`default_nettype wire

// [dv/pacl_assertions.sv]
// bus and lookup checker for the rule table access block
`timescale 1ns/1ps
`default_nettype none
module pacl_assertions (
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire logic [pacl_pkg::ADR_W-1:0]  wb_adr_i,
    input wire logic [31:0]                 wb_dat_i,
    input wire logic [31:0]                 wb_dat_o,
    input wire logic                        wb_we_i,
    input wire logic [3:0]                  wb_sel_i,
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire logic                        wb_ack_o,
    input wire logic [3:0]                  match_index_i,
    input wire logic [pacl_pkg::RULE_W-1:0] match_rule_o,
    input wire logic [1:0]                  match_mode_o
);
    import pacl_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_take = take && !wb_we_i;
    a_ack_after_take: assert property (take |=> wb_ack_o) else $error("no ack after request");
    a_no_stray_ack: assert property (!take |=> !wb_ack_o) else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_unmapped_zero: assert property (rd_take && wb_adr_i[7:2] > IDX_CTRL |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_flags_idle: assert property (rd_take && wb_adr_i[7:2] == IDX_CTRL |=> wb_dat_o[7:5] == 3'b011)
        else $error("done flags low when idle");
    a_mode_field: assert property (match_mode_o == match_rule_o[8*MODE_BYTE+MODE_LSB +: 2])
        else $error("mode field mismatch");
    a_rule_steady: assert property ((!(wb_cyc_i && wb_we_i) && $stable(match_index_i)) [*4] |=>
        $stable(match_rule_o)) else $error("entry changed without write");
    a_reset_quiet: assert property ($past(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0 && match_rule_o == '0)
        else $error("outputs not cleared by reset");
    c_launch: cover property (take && wb_we_i && wb_adr_i[7:2] == IDX_MASK_LO);
    c_ctrl_read: cover property (rd_take && wb_adr_i[7:2] == IDX_CTRL);
    c_mode_l4: cover property (match_mode_o == PACL_MODE_L4);
endmodule
bind pacl_top pacl_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .match_index_i(match_index_i), .match_rule_o(match_rule_o), .match_mode_o(match_mode_o));
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the rule table access block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pacl_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat, dat_o;
    logic [3:0] sel, m_idx;
    logic [RULE_W-1:0] m_rule;
    pacl_mode_t m_mode;
    logic [7:0] stage [N_BYTES];
    logic [7:0] tbl [N_ENTRIES][N_BYTES];
    logic [7:0] q;
    integer seed, errors, check_count, cyc_cnt;
    pacl_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .match_index_i(m_idx), .match_rule_o(m_rule), .match_mode_o(m_mode));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [RULE_W-1:0] seen, input logic [RULE_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            errors++;
            results();
        end
    end
    // one classic cycle; read byte lands in q
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, d};
        sel <= s;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic logic [15:0] byte_en(input logic [7:0] mh, input logic [7:0] ml);
        logic [15:0] e;
        for (int i = 0; i < 8; i++) begin
            e[7 - i] = mh[i];
            e[15 - i] = ml[i];
        end
        return e;
    endfunction
    function automatic logic [RULE_W-1:0] entry(input logic [3:0] n);
        logic [RULE_W-1:0] r;
        for (int k = 0; k < N_BYTES; k++) r[8*k +: 8] = tbl[n][k];
        return r;
    endfunction
    initial begin
        logic [7:0] mh, ml;
        logic [15:0] en;
        logic dir;
        logic [3:0] idx;
        seed = 32'hff93;
        errors = 0;
        check_count = 0;
        cyc_cnt = 0;
        {cyc, stb, we, sel, adr, dat, m_idx} = '0;
        rst_i = 1'b1;
        for (int n = 0; n < N_ENTRIES * N_BYTES; n++) tbl[n / 16][n % 16] = 8'h00;
        for (int k = 0; k < N_BYTES; k++) stage[k] = 8'h00;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int r = 0; r < 19; r++) begin
            wb(1'b0, r[5:0], 8'h00, 4'hf);
            chk(q, (r == 18) ? 8'h60 : 8'h00);
        end
        wb(1'b1, 6'h13, 8'h5a, 4'hf);
        wb(1'b0, 6'h13, 8'h00, 4'hf);
        chk(q, 8'h00);
        wb(1'b1, 6'h03, 8'haa, 4'he);
        wb(1'b0, 6'h03, 8'h00, 4'hf);
        chk(q, 8'h00);
        for (int it = 0; it < 30; it++) begin
            for (int k = 0; k < N_BYTES; k++) begin
                stage[k] = 8'($random(seed));
                wb(1'b1, k[5:0], stage[k], 4'h1);
            end
            mh = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : (it == 2) ? 8'h01 : 8'($random(seed));
            ml = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : (it == 2) ? 8'h80 : 8'($random(seed));
            dir = (it < 3) ? 1'b1 : 1'($random(seed));
            idx = (it < 3) ? 4'h5 : 4'($random(seed));
            wb(1'b1, IDX_MASK_HI, mh, 4'h1);
            wb(1'b1, IDX_CTRL, {3'b111, dir, idx}, 4'h1);
            en = byte_en(mh, ml);
            for (int k = 0; k < N_BYTES; k++) begin
                if (en[k] && dir) tbl[idx][k] = stage[k];
                else if (en[k]) stage[k] = tbl[idx][k];
            end
            wb(1'b1, IDX_MASK_LO, ml, 4'h1);
            wb(1'b0, IDX_CTRL, 8'h00, 4'h1);
            chk(q, {3'b011, dir, idx});
            for (int k = 0; k < N_BYTES; k++) begin
                wb(1'b0, k[5:0], 8'h00, 4'h1);
                chk(q, stage[k]);
            end
            @(posedge clk_i);
            m_idx <= idx;
            repeat (3) @(posedge clk_i);
            chk(m_rule, entry(idx));
            chk(m_mode, tbl[idx][MODE_BYTE][MODE_LSB +: 2]);
        end
        results();
    end
endmodule
`default_nettype wire
